/* src/ccuif_pkg.sv */
// constants for the capture/compare interrupt flag and enable block
package ccuif_pkg;
	localparam int          CCUIF_AW               = 8;
	localparam int          CCUIF_DW               = 8;
	// register offsets
	localparam logic [7:0]  CCUIF_ADDR_ENABLE      = 8'hC9;
	localparam logic [7:0]  CCUIF_ADDR_FLAGS       = 8'hE9;
	localparam logic [7:0]  CCUIF_ADDR_SRC_CODE    = 8'hDE;
	localparam logic [7:0]  CCUIF_ADDR_CTRL        = 8'hD0;
	localparam logic [7:0]  CCUIF_ADDR_STATUS      = 8'hD1;
	localparam logic [7:0]  CCUIF_ADDR_EVT_EN      = 8'hD2;
	localparam logic [7:0]  CCUIF_ADDR_EVT_CLR     = 8'hD3;
	// flag and enable bit positions
	localparam int          CCUIF_BIT_CAP_A        = 0;
	localparam int          CCUIF_BIT_CAP_B        = 1;
	localparam int          CCUIF_BIT_RSVD         = 2;
	localparam int          CCUIF_BIT_CMP_A        = 3;
	localparam int          CCUIF_BIT_CMP_D        = 6;
	localparam int          CCUIF_BIT_OVF          = 7;
	// control register bits
	localparam int          CCUIF_CTRL_GIE         = 0;
	localparam int          CCUIF_CTRL_SRC_EN      = 1;
	localparam int          CCUIF_CTRL_CMP_EN_LSB  = 4;
	// status event bits
	localparam int          CCUIF_EVT_REQ_RISE     = 0;
	localparam int          CCUIF_EVT_CODE_CHG     = 1;
	// reset values and implemented-bit mask
	localparam logic [7:0]  CCUIF_RST_FLAGS        = 8'h00;
	localparam logic [7:0]  CCUIF_RST_ENABLE       = 8'h00;
	localparam logic [7:0]  CCUIF_RST_CTRL         = 8'h00;
	localparam logic [1:0]  CCUIF_RST_EVT          = 2'h0;
	localparam logic [7:0]  CCUIF_MASK_IMPL        = 8'hFB;
	// source codes
	localparam logic [2:0]  CCUIF_CODE_NONE        = 3'h0;
	localparam logic [2:0]  CCUIF_CODE_CMP_D       = 3'h1;
	localparam logic [2:0]  CCUIF_CODE_CMP_C       = 3'h2;
	localparam logic [2:0]  CCUIF_CODE_CMP_B       = 3'h3;
	localparam logic [2:0]  CCUIF_CODE_CMP_A       = 3'h4;
	localparam logic [2:0]  CCUIF_CODE_CAP_B       = 3'h5;
	localparam logic [2:0]  CCUIF_CODE_CAP_A       = 3'h6;
	localparam logic [2:0]  CCUIF_CODE_OVF         = 3'h7;
endpackage : ccuif_pkg

/* src/ccuif_prio_enc.sv */
// fixed-priority encoder of the gated flags into the 3-bit source code
`timescale 1ns/1ps
module ccuif_prio_enc
	import ccuif_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [7:0] pending,
	output logic      [2:0] code_r
);
	logic [2:0] code_nxt;

	always_comb begin
		code_nxt = CCUIF_CODE_NONE;
		if (pending[CCUIF_BIT_OVF])
			code_nxt = CCUIF_CODE_OVF;
		else if (pending[CCUIF_BIT_CAP_A])
			code_nxt = CCUIF_CODE_CAP_A;
		else if (pending[CCUIF_BIT_CAP_B])
			code_nxt = CCUIF_CODE_CAP_B;
		else if (pending[CCUIF_BIT_CMP_A])
			code_nxt = CCUIF_CODE_CMP_A;
		else if (pending[CCUIF_BIT_CMP_A + 1])
			code_nxt = CCUIF_CODE_CMP_B;
		else if (pending[CCUIF_BIT_CMP_A + 2])
			code_nxt = CCUIF_CODE_CMP_C;
		else if (pending[CCUIF_BIT_CMP_D])
			code_nxt = CCUIF_CODE_CMP_D;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			code_r <= CCUIF_CODE_NONE;
		else
			code_r <= code_nxt;
	end
endmodule : ccuif_prio_enc

/* src/ccuif_top.sv */
// interrupt flags, enables and request of the capture/compare timer unit
// Function
// - capture A event sets flag bit 0, held until software clears it
// - capture B event sets flag bit 1, held until software clears it
// - timer equal to compare A sets flag bit 3 while channel A enabled
// - timer equal to compare B sets flag bit 4 while channel B enabled
// - timer equal to compare C sets flag bit 5 while channel C enabled
// - timer equal to compare D sets flag bit 6 while channel D enabled
// - timer overflow sets flag bit 7, held until software clears it
// - compare interrupt needs global enable, unit source enable and channel enable
// - enable bits 0 and 1 gate capture A and B interrupts
// - enable bits 3 to 6 gate compare A to D interrupts
// - enable bit 7 gates the overflow interrupt
// - gated flags priority-encode to a 3-bit code, overflow highest, compare D lowest
// - writing zero to a flag bit clears it; writing one leaves it
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module ccuif_top
	import ccuif_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rstn,
	input  wire logic [CCUIF_AW-1:0] addr,
	input  wire logic [CCUIF_DW-1:0] wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic      [CCUIF_DW-1:0] rdata,
	input  wire logic                capture_a_event,
	input  wire logic                capture_b_event,
	input  wire logic                timer_overflow_event,
	input  wire logic [15:0]         timer_value,
	input  wire logic [15:0]         compare_a_value,
	input  wire logic [15:0]         compare_b_value,
	input  wire logic [15:0]         compare_c_value,
	input  wire logic [15:0]         compare_d_value,
	output logic                     ccu_irq_req,
	output logic      [2:0]          encoded_interrupt_source,
	output logic                     ccu_evt_irq
);
	logic [7:0]          ccu_interrupt_flags_r;
	logic [7:0]          ccu_interrupt_flags_nxt;
	logic [7:0]          ccu_interrupt_enable_r;
	logic [7:0]          ctrl_r;
	logic [1:0]          evt_status_r;
	logic [1:0]          evt_enable_r;
	logic [7:0]          hw_set;
	logic [7:0]          pending;
	logic [3:0]          cmp_match;
	logic [15:0]         cmp_val [4];
	logic [2:0]          code_r;
	logic [2:0]          code_prev_r;
	logic                req_nxt;
	logic                req_prev_r;
	logic [1:0]          evt_set;
	logic [CCUIF_DW-1:0] rdata_nxt;
	logic                global_interrupt_enable;
	logic                capture_unit_source_enable;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	assign global_interrupt_enable    = ctrl_r[CCUIF_CTRL_GIE];
	assign capture_unit_source_enable = ctrl_r[CCUIF_CTRL_SRC_EN];
	assign cmp_val[0] = compare_a_value;
	assign cmp_val[1] = compare_b_value;
	assign cmp_val[2] = compare_c_value;
	assign cmp_val[3] = compare_d_value;

	// compare matches count only while the channel itself is switched on
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			assign cmp_match[g] = ctrl_r[CCUIF_CTRL_CMP_EN_LSB + g]
				&& (timer_value == cmp_val[g]);
			assign hw_set[CCUIF_BIT_CMP_A + g] = cmp_match[g];
		end
	endgenerate

	assign hw_set[CCUIF_BIT_CAP_A] = capture_a_event;
	assign hw_set[CCUIF_BIT_CAP_B] = capture_b_event;
	assign hw_set[CCUIF_BIT_RSVD]  = 1'b0;
	assign hw_set[CCUIF_BIT_OVF]   = timer_overflow_event;

	// a hardware set in the same cycle as a clearing write wins
	always_comb begin
		ccu_interrupt_flags_nxt = ccu_interrupt_flags_r;
		if (wr && hit(addr, CCUIF_ADDR_FLAGS))
			ccu_interrupt_flags_nxt = ccu_interrupt_flags_r & wdata;
		ccu_interrupt_flags_nxt = (ccu_interrupt_flags_nxt | hw_set) & CCUIF_MASK_IMPL;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ccu_interrupt_flags_r <= CCUIF_RST_FLAGS;
		else
			ccu_interrupt_flags_r <= ccu_interrupt_flags_nxt;
	end

	// reserved bit 2 is not stored, so a stray one from software does no harm
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ccu_interrupt_enable_r <= CCUIF_RST_ENABLE;
		else if (wr && hit(addr, CCUIF_ADDR_ENABLE))
			ccu_interrupt_enable_r <= wdata & CCUIF_MASK_IMPL;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ctrl_r <= CCUIF_RST_CTRL;
		else if (wr && hit(addr, CCUIF_ADDR_CTRL))
			ctrl_r <= wdata;
	end

	assign pending = ccu_interrupt_flags_r & ccu_interrupt_enable_r;

	ccuif_prio_enc u_enc (
		.mclk    (mclk),
		.rstn    (rstn),
		.pending (pending),
		.code_r  (code_r)
	);

	// capture and overflow need only the global enable; compare also needs
	// the unit source enable
	assign req_nxt = global_interrupt_enable && (
		(|pending[CCUIF_BIT_CAP_B:CCUIF_BIT_CAP_A]) || pending[CCUIF_BIT_OVF] ||
		(capture_unit_source_enable && (|pending[CCUIF_BIT_CMP_D:CCUIF_BIT_CMP_A])));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ccu_irq_req <= 1'b0;
		else
			ccu_irq_req <= req_nxt;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			req_prev_r  <= 1'b0;
			code_prev_r <= CCUIF_CODE_NONE;
		end else begin
			req_prev_r  <= req_nxt;
			code_prev_r <= code_r;
		end
	end

	assign encoded_interrupt_source = code_r;

	// sticky events: request rise and source code change
	assign evt_set[CCUIF_EVT_REQ_RISE] = req_nxt && !req_prev_r;
	assign evt_set[CCUIF_EVT_CODE_CHG] = code_r != code_prev_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			evt_status_r <= CCUIF_RST_EVT;
		else if (wr && hit(addr, CCUIF_ADDR_EVT_CLR))
			evt_status_r <= (evt_status_r & ~wdata[1:0]) | evt_set;
		else
			evt_status_r <= evt_status_r | evt_set;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			evt_enable_r <= CCUIF_RST_EVT;
		else if (wr && hit(addr, CCUIF_ADDR_EVT_EN))
			evt_enable_r <= wdata[1:0];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ccu_evt_irq <= 1'b0;
		else
			ccu_evt_irq <= |(evt_status_r & evt_enable_r);
	end

	always_comb begin
		rdata_nxt = 8'h00;
		case (addr)
			CCUIF_ADDR_FLAGS:    rdata_nxt = ccu_interrupt_flags_r;
			CCUIF_ADDR_ENABLE:   rdata_nxt = ccu_interrupt_enable_r;
			CCUIF_ADDR_SRC_CODE: rdata_nxt = {5'h00, code_r};
			CCUIF_ADDR_CTRL:     rdata_nxt = ctrl_r;
			CCUIF_ADDR_STATUS:   rdata_nxt = {6'h00, evt_status_r};
			CCUIF_ADDR_EVT_EN:   rdata_nxt = {6'h00, evt_enable_r};
			default:             rdata_nxt = 8'h00;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rdata <= 8'h00;
		else if (rd)
			rdata <= rdata_nxt;
		else
			rdata <= 8'h00;
	end
endmodule : ccuif_top

/* verif/ccuif_assertions.sv */
// port checker for the capture/compare interrupt block
`timescale 1ns/1ps
module ccuif_assertions
	import ccuif_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       ccu_irq_req,
	input wire logic [2:0] encoded_interrupt_source
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// hardware only ever adds flags, so without a write the code cannot fall
	sequence s_no_write;
		!$past(wr);
	endsequence
	sequence s_en_off;
		wr && addr == CCUIF_ADDR_ENABLE && wdata == 8'h00 ##1 !wr;
	endsequence
	sequence s_flags_ones;
		wr && addr == CCUIF_ADDR_FLAGS && wdata == 8'hFB ##1 !wr;
	endsequence
	chk_irq_has_code: assert property (ccu_irq_req |-> encoded_interrupt_source != 3'h0)
		else $error("request with no source code");
	chk_code_no_drop: assert property (s_no_write |=>
		encoded_interrupt_source >= $past(encoded_interrupt_source))
		else $error("source code fell without a write");
	chk_irq_sticky: assert property (ccu_irq_req && !$past(wr) |=> ccu_irq_req)
		else $error("request dropped without a write");
	chk_enable_off: assert property (s_en_off |=>
		encoded_interrupt_source == CCUIF_CODE_NONE && !ccu_irq_req)
		else $error("source left after enables cleared");
	chk_code_read: assert property (rd && addr == CCUIF_ADDR_SRC_CODE |=>
		rdata[2:0] == $past(encoded_interrupt_source))
		else $error("source code register differs from port");
	chk_rsvd_zero: assert property (rd && (addr == CCUIF_ADDR_ENABLE ||
		addr == CCUIF_ADDR_FLAGS) |=> !rdata[2])
		else $error("reserved bit reads one");
	chk_ones_keep: assert property (s_flags_ones |=>
		encoded_interrupt_source >= $past(encoded_interrupt_source))
		else $error("writing ones cleared a flag");
	chk_ovf_holds: assert property (encoded_interrupt_source == CCUIF_CODE_OVF &&
		!$past(wr) |=> encoded_interrupt_source == CCUIF_CODE_OVF)
		else $error("overflow lost top priority");
endmodule : ccuif_assertions
bind ccuif_top ccuif_assertions u_ccuif_assertions (.mclk, .rstn, .addr, .wdata, .wr, .rd,
	.rdata, .ccu_irq_req, .encoded_interrupt_source);

/* verif/ccuif_timer_model.sv */
// free-running 16-bit timer driving the compare and overflow inputs
`timescale 1ns/1ps
module ccuif_timer_model (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	output logic      [15:0] timer_value,
	output logic             overflow
);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			timer_value <= 16'h0000;
			overflow    <= 1'b0;
		end else begin
			timer_value <= load ? load_val : timer_value + 16'h0001;
			overflow    <= !load && timer_value == 16'hFFFF;
		end
	end
endmodule : ccuif_timer_model

/* verif/tb_top.sv */
// self-checking bench for the capture/compare interrupt block
`timescale 1ns/1ps
module tb_top;
	import ccuif_pkg::*;
	logic        mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, load = 1'b0;
	logic        cap_a = 1'b0, cap_b = 1'b0, ovf, irq, evt_irq;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
	logic [2:0]  code;
	logic [15:0] tval;
	int          err_total = 0, checked = 0, cycles = 0;
	int          order[7] = '{7, 0, 1, 3, 4, 5, 6};
	always #50 mclk = ~mclk;
	ccuif_timer_model u_ccuif_timer_model (.mclk, .rstn, .load, .load_val(16'hFFF0),
		.timer_value(tval), .overflow(ovf));
	ccuif_top u_ccuif_top (.mclk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
		.capture_a_event(cap_a), .capture_b_event(cap_b), .timer_overflow_event(ovf),
		.timer_value(tval), .compare_a_value(16'hFFF2), .compare_b_value(16'hFFF3),
		.compare_c_value(16'hFFF4), .compare_d_value(16'hFFF5), .ccu_irq_req(irq),
		.encoded_interrupt_source(code), .ccu_evt_irq(evt_irq));
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1 cmp($sformatf("reg %h", a), exp, rdata);
	endtask : rd_chk
	task automatic port_chk(input logic [2:0] c, input logic q);
		repeat (2) @(posedge mclk);
		#1 cmp("code", {5'h00, c}, {5'h00, code});
		cmp("irq", {7'h00, q}, {7'h00, irq});
	endtask : port_chk
	// the sweep runs the timer through all four compare values and the wrap
	task automatic sweep(input logic c);
		@(posedge mclk);
		cap_a <= c;
		cap_b <= c;
		load  <= 1'b1;
		@(posedge mclk);
		cap_a <= 1'b0;
		cap_b <= 1'b0;
		load  <= 1'b0;
		repeat (20) @(posedge mclk);
	endtask : sweep
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		rd_chk(CCUIF_ADDR_ENABLE, CCUIF_RST_ENABLE);
		rd_chk(CCUIF_ADDR_FLAGS, CCUIF_RST_FLAGS);
		wr_reg(CCUIF_ADDR_ENABLE, 8'hFB);
		rd_chk(CCUIF_ADDR_ENABLE, 8'hFB);
		rd_chk(8'h00, 8'h00);
		$display("test registers done");
		wr_reg(CCUIF_ADDR_CTRL, 8'hF3);
		sweep(1'b1);
		rd_chk(CCUIF_ADDR_FLAGS, 8'hFB);
		wr_reg(CCUIF_ADDR_FLAGS, 8'hFB);
		rd_chk(CCUIF_ADDR_STATUS, 8'h03);
		cmp("evt_irq", 8'h00, {7'h00, evt_irq});
		wr_reg(CCUIF_ADDR_EVT_EN, 8'h01);
		rd_chk(CCUIF_ADDR_FLAGS, 8'hFB);
		cmp("evt_irq", 8'h01, {7'h00, evt_irq});
		wr_reg(CCUIF_ADDR_EVT_CLR, 8'h03);
		rd_chk(CCUIF_ADDR_STATUS, 8'h00);
		cmp("evt_irq", 8'h00, {7'h00, evt_irq});
		foreach (order[k]) begin
			port_chk(3'(7 - k), 1'b1);
			wr_reg(CCUIF_ADDR_FLAGS, 8'hFB & ~(8'h01 << order[k]));
		end
		port_chk(CCUIF_CODE_NONE, 1'b0);
		$display("test priority done");
		wr_reg(CCUIF_ADDR_ENABLE, 8'h08);
		wr_reg(CCUIF_ADDR_CTRL, 8'h11);
		sweep(1'b0);
		rd_chk(CCUIF_ADDR_FLAGS, 8'h88);
		port_chk(CCUIF_CODE_CMP_A, 1'b0);
		wr_reg(CCUIF_ADDR_CTRL, 8'h13);
		port_chk(CCUIF_CODE_CMP_A, 1'b1);
		wr_reg(CCUIF_ADDR_ENABLE, 8'h00);
		port_chk(CCUIF_CODE_NONE, 1'b0);
		wr_reg(CCUIF_ADDR_FLAGS, 8'h00);
		wr_reg(CCUIF_ADDR_ENABLE, 8'h01);
		wr_reg(CCUIF_ADDR_CTRL, 8'h01);
		sweep(1'b1);
		rd_chk(CCUIF_ADDR_FLAGS, 8'h83);
		port_chk(CCUIF_CODE_CAP_A, 1'b1);
		rd_chk(CCUIF_ADDR_SRC_CODE, {5'h00, CCUIF_CODE_CAP_A});
		$display("test gating done");
		give_verdict();
	end
endmodule : tb_top
